// File: bench/aacr_host_model.sv
/*
 holds a behavioural I2C controller that plays the host side of the control port.
 assumes the bench resolves the open-drain data line with a pull-up and feeds it back on sda.
*/
`timescale 1ns/1ps
module aacr_host_model (
   input wire logic clk, // bench clock, 50 ns
   output logic scl, // i2c clock, high while idle
   output logic sda_oe, // host pulls sda low
   input wire logic sda // resolved data line
);
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // -----------------------------------------------
   // bus phases, 4 clk low and 4 clk high per bit
   // -----------------------------------------------
   task automatic clk_n(input int n);
      repeat (n) @(posedge clk);
   endtask
   // data moves 150 ns after the fall so the target's synchroniser sees a clean setup
   task automatic bit_x(input logic b, output logic r);
      clk_n(3);
      sda_oe <= ~b;
      clk_n(1);
      scl <= 1'b1;
      clk_n(2);
      r = sda;
      clk_n(2);
      scl <= 1'b0;
   endtask
   task automatic start_c();
      clk_n(1);
      sda_oe <= 1'b1;
      clk_n(4);
      scl <= 1'b0;
   endtask
   task automatic stop_c();
      clk_n(3);
      sda_oe <= 1'b1;
      clk_n(1);
      scl <= 1'b1;
      clk_n(4);
      sda_oe <= 1'b0;
      clk_n(4);
   endtask
   task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(last, a);
      ack = ~a;
   endtask
   // reserved fields are written only with reset values by the caller's choice of data
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d, output logic ack);
      logic [7:0] q;
      logic t;
      start_c();
      byte_x({a, 1'b0}, 1'b1, q, ack);
      if (ack) begin
         byte_x(ofs, 1'b1, q, t);
         byte_x(d, 1'b1, q, t);
      end
      stop_c();
   endtask
   task automatic rd_reg(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] q, output logic ack);
      logic t;
      start_c();
      byte_x({a, 1'b0}, 1'b1, q, ack);
      byte_x(ofs, 1'b1, q, t);
      stop_c();
      start_c();
      byte_x({a, 1'b1}, 1'b1, q, t);
      byte_x(8'hff, 1'b1, q, t);
      stop_c();
   endtask
endmodule

// File: bench/tb_audio_adc_control_registers.sv
/*
 holds the self-checking bench of the control register bank, driven over I2C by the host model.
 assumes short charge counts set through the design's parameters.
*/
`timescale 1ns/1ps
module tb_audio_adc_control_registers;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic scl, host_oe, sda_out, sda_oe, supply, bcast, sleep_n, ref_act, cap_act, fs_inv, bc_inv, e_inv, fill;
   logic [7:0] page, q;
   logic [1:0] fmt, wlen;
   logic [5:0] wbits;
   logic a;
   logic [7:0] v;
   logic [5:0] bits_tab [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
   wire logic sda_line = ~(host_oe | sda_oe); // pull-up wins when nobody pulls low
   int error_cnt = 0;
   int check_count = 0;
   int ref_run = 0, cap_run = 0, ref_len = 0, cap_len = 0;
   always #25 clk = ~clk;
   aacr_host_model aacr_host_model_inst (.clk(clk), .scl(scl), .sda_oe(host_oe), .sda(sda_line));
   audio_adc_control_registers #(.REF_CYC('{10, 20, 30, 40}), .INCAP_CYC('{15, 25, 35, 45}))
      audio_adc_control_registers_inst (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .page_sel(page), .analog_supply_source(supply),
      .broadcast_address_enable(bcast), .sleep_exit_n(sleep_n), .ref_charge_active(ref_act),
      .input_cap_charge_active(cap_act), .frame_format(fmt), .audio_word_length(wlen),
      .audio_word_bits(wbits), .frame_sync_invert(fs_inv), .bit_clock_invert(bc_inv),
      .tx_edge_invert(e_inv), .tx_fill_hiz(fill));
   // charge windows are measured as runs of high cycles
   always @(posedge clk) begin
      if (ref_act === 1'b1) ref_run <= ref_run + 1;
      else if (ref_run != 0) begin
         ref_len <= ref_run;
         ref_run <= 0;
      end
      if (cap_act === 1'b1) cap_run <= cap_run + 1;
      else if (cap_run != 0) begin
         cap_len <= cap_run;
         cap_run <= 0;
      end
   end
   // -----------------------------------------------
   // checks and register access
   // -----------------------------------------------
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      chk8(n, {7'h0, e}, {7'h0, g});
   endtask
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      aacr_host_model_inst.wr_reg(7'h2a, ofs, d, a);
      chk1("write ack", 1'b1, a);
   endtask
   task automatic rd(input logic [7:0] ofs, input logic [7:0] e);
      aacr_host_model_inst.rd_reg(7'h2a, ofs, q, a);
      chk8($sformatf("reg %h", ofs), e, q);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #3000000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      rd(aacr_pkg::OFS_PAGE, 8'h00);
      rd(aacr_pkg::OFS_SRST, 8'h00);
      rd(aacr_pkg::OFS_SLEEP, 8'h00);
      rd(aacr_pkg::OFS_SHDN, 8'h05);
      rd(aacr_pkg::OFS_ASI, 8'h30);
      rd(8'h03, 8'h00);
      aacr_host_model_inst.rd_reg(7'h11, aacr_pkg::OFS_PAGE, q, a);
      chk1("foreign address ack", 1'b0, a);
      chk1("sda level", 1'b0, sda_out);
      for (int i = 0; i < 16; i++) begin
         v = {2'(i % 3), 2'(i >> 2), 4'(i)};
         wr(aacr_pkg::OFS_ASI, v);
         chk8("format", {6'h0, v[7:6]}, {6'h0, fmt});
         chk8("word bits", {2'h0, bits_tab[v[5:4]]}, {2'h0, wbits});
         chk8("word code", {6'h0, v[5:4]}, {6'h0, wlen});
         chk8("flags", {4'h0, v[3:0]}, {4'h0, fs_inv, bc_inv, e_inv, fill});
      end
      rd(aacr_pkg::OFS_ASI, 8'h3f);
      wr(aacr_pkg::OFS_PAGE, 8'hff);
      rd(aacr_pkg::OFS_PAGE, 8'hff);
      chk8("page port", 8'hff, page);
      wr(aacr_pkg::OFS_ASI, 8'h12);
      rd(aacr_pkg::OFS_ASI, 8'h00);
      wr(aacr_pkg::OFS_PAGE, 8'h00);
      rd(aacr_pkg::OFS_ASI, 8'h3f);
      wr(aacr_pkg::OFS_ASI, 8'h00);
      chk8("word bits", 8'h10, {2'h0, wbits});
      wr(aacr_pkg::OFS_SHDN, 8'h35);
      wr(aacr_pkg::OFS_SLEEP, 8'h9d);
      rd(aacr_pkg::OFS_SLEEP, 8'h9d);
      rd(aacr_pkg::OFS_SHDN, 8'h35);
      chk8("ref time", 8'h28, 8'(ref_len));
      chk8("cap time", 8'h2d, 8'(cap_len));
      chk1("supply", 1'b1, supply);
      chk1("awake", 1'b1, sleep_n);
      wr(aacr_pkg::OFS_SLEEP, 8'h00);
      chk1("asleep", 1'b0, sleep_n);
      wr(aacr_pkg::OFS_SHDN, 8'h05);
      wr(aacr_pkg::OFS_SLEEP, 8'h8d);
      rd(aacr_pkg::OFS_SLEEP, 8'h8d);
      chk8("ref time", 8'h14, 8'(ref_len));
      chk8("cap time", 8'h0f, 8'(cap_len));
      chk1("bcast port", 1'b1, bcast);
      aacr_host_model_inst.rd_reg(7'h4c, aacr_pkg::OFS_SLEEP, q, a);
      chk1("bcast ack", 1'b1, a);
      chk8("bcast read", 8'h8d, q);
      wr(aacr_pkg::OFS_SLEEP, 8'h00);
      aacr_host_model_inst.rd_reg(7'h4c, aacr_pkg::OFS_SLEEP, q, a);
      chk1("bcast off ack", 1'b0, a);
      wr(aacr_pkg::OFS_SLEEP, 8'h9d);
      wr(aacr_pkg::OFS_SRST, 8'h00);
      rd(aacr_pkg::OFS_SLEEP, 8'h9d);
      wr(aacr_pkg::OFS_SRST, 8'h01);
      rd(aacr_pkg::OFS_SRST, 8'h00);
      rd(aacr_pkg::OFS_SLEEP, 8'h00);
      rd(aacr_pkg::OFS_SHDN, 8'h05);
      rd(aacr_pkg::OFS_ASI, 8'h30);
      chk8("word bits", 8'h20, {2'h0, wbits});
      chk1("supply", 1'b0, supply);
      conclude();
   end
endmodule

// File: hdl/aacr_i2c_target.sv
/*
 holds the I2C target of the control port: address match, register pointer, auto-increment
 writes and reads.
 assumes scl and sda come straight from pins; sda is open drain, driven low only.
*/
`timescale 1ns/1ps
module aacr_i2c_target #(
   parameter logic [6:0] OWN_ADDR = 7'h2a // arbitrary target address
) (
   input wire logic clk, // system clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic scl_in, // i2c clock pin
   input wire logic sda_in, // i2c data pin level
   output logic sda_oe, // pull sda low
   input wire logic bcast_en, // also answer the broadcast address
   output logic [7:0] reg_addr, // register pointer
   output logic [7:0] wr_data, // written byte
   output logic wr_stb, // one-cycle write strobe
   input wire logic [7:0] rd_data // read data at reg_addr
);
   // ---------------------------------------------------------------
   // pin synchronisers and bus events
   // ---------------------------------------------------------------
   logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         {scl_s1, scl_s2, scl_d} <= 3'h7;
         {sda_s1, sda_s2, sda_d} <= 3'h7;
      end else begin
         {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
      end
   end
   wire rise = scl_s2 && !scl_d;
   wire fall = !scl_s2 && scl_d;
   wire start = scl_s2 && scl_d && sda_d && !sda_s2;
   wire stop = scl_s2 && scl_d && !sda_d && sda_s2;

   // ---------------------------------------------------------------
   // byte engine
   // ---------------------------------------------------------------
   aacr_pkg::aacr_i2c_e st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt;
   logic rw_r, rw_nxt, oe_r, oe_nxt, nack_r, nack_nxt, wr_r, wr_nxt;

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      ptr_nxt = ptr_r;
      rw_nxt = rw_r;
      oe_nxt = oe_r;
      nack_nxt = nack_r;
      wr_nxt = 1'b0;
      if (start) begin
         st_nxt = aacr_pkg::ST_ADDR;
         cnt_nxt = 4'h0;
         oe_nxt = 1'b0;
      end else if (stop) begin
         st_nxt = aacr_pkg::ST_IDLE;
         oe_nxt = 1'b0;
      end else if (rise) begin
         case (st_r)
            aacr_pkg::ST_ADDR, aacr_pkg::ST_PTR, aacr_pkg::ST_WR: begin
               sh_nxt = {sh_r[6:0], sda_s2};
               cnt_nxt = cnt_r + 4'h1;
            end
            aacr_pkg::ST_RACK: nack_nxt = sda_s2;
            default: ;
         endcase
      end else if (fall) begin
         case (st_r)
            aacr_pkg::ST_ADDR: begin
               if (cnt_r == 4'h8) begin
                  if (sh_r[7:1] == OWN_ADDR || (bcast_en && sh_r[7:1] == aacr_pkg::BCAST_ADDR)) begin
                     st_nxt = aacr_pkg::ST_AACK;
                     rw_nxt = sh_r[0];
                     oe_nxt = 1'b1;
                  end else begin
                     st_nxt = aacr_pkg::ST_IDLE;
                  end
               end
            end
            aacr_pkg::ST_AACK: begin
               oe_nxt = 1'b0;
               cnt_nxt = 4'h0;
               if (rw_r) begin
                  sh_nxt = rd_data;
                  ptr_nxt = ptr_r + 8'h01;
                  st_nxt = aacr_pkg::ST_RD;
                  oe_nxt = !rd_data[7];
               end else begin
                  st_nxt = aacr_pkg::ST_PTR;
               end
            end
            aacr_pkg::ST_PTR: begin
               if (cnt_r == 4'h8) begin
                  ptr_nxt = sh_r;
                  st_nxt = aacr_pkg::ST_PACK;
                  oe_nxt = 1'b1;
               end
            end
            aacr_pkg::ST_PACK: begin
               oe_nxt = 1'b0;
               cnt_nxt = 4'h0;
               st_nxt = aacr_pkg::ST_WR;
            end
            aacr_pkg::ST_WR: begin
               if (cnt_r == 4'h8) begin
                  wr_nxt = 1'b1;
                  st_nxt = aacr_pkg::ST_WACK;
                  oe_nxt = 1'b1;
               end
            end
            aacr_pkg::ST_WACK: begin
               oe_nxt = 1'b0;
               cnt_nxt = 4'h0;
               ptr_nxt = ptr_r + 8'h01;
               st_nxt = aacr_pkg::ST_WR;
            end
            aacr_pkg::ST_RD: begin
               sh_nxt = {sh_r[6:0], 1'b0};
               cnt_nxt = cnt_r + 4'h1;
               if (cnt_r == 4'h7) begin
                  st_nxt = aacr_pkg::ST_RACK;
                  oe_nxt = 1'b0;
               end else begin
                  oe_nxt = !sh_r[6];
               end
            end
            aacr_pkg::ST_RACK: begin
               if (nack_r) begin
                  st_nxt = aacr_pkg::ST_IDLE;
               end else begin
                  sh_nxt = rd_data;
                  ptr_nxt = ptr_r + 8'h01;
                  cnt_nxt = 4'h0;
                  st_nxt = aacr_pkg::ST_RD;
                  oe_nxt = !rd_data[7];
               end
            end
            default: st_nxt = aacr_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r <= aacr_pkg::ST_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         ptr_r <= 8'h00;
         rw_r <= 1'b0;
         oe_r <= 1'b0;
         nack_r <= 1'b0;
         wr_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         ptr_r <= ptr_nxt;
         rw_r <= rw_nxt;
         oe_r <= oe_nxt;
         nack_r <= nack_nxt;
         wr_r <= wr_nxt;
      end
   end

   assign sda_oe = oe_r;
   assign reg_addr = ptr_r;
   assign wr_data = sh_r;
   assign wr_stb = wr_r;
endmodule

// File: hdl/aacr_pkg.sv
/*
 holds offsets, reset values, field positions, encodings and timing figures of the
 audio ADC control register bank.
 assumes a single 20 MHz system clock.
*/
package aacr_pkg;
   // ---------------------------------------------------------------
   // register offsets (page 0) and values after reset
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_PAGE = 8'h00;
   localparam logic [7:0] OFS_SRST = 8'h01;
   localparam logic [7:0] OFS_SLEEP = 8'h02;
   localparam logic [7:0] OFS_SHDN = 8'h05;
   localparam logic [7:0] OFS_ASI = 8'h07;
   localparam logic [7:0] PAGE_ZERO = 8'h00;
   localparam logic [7:0] RST_PAGE = 8'h00;
   localparam logic [7:0] RST_SLEEP = 8'h00;
   localparam logic [7:0] RST_SHDN = 8'h05;
   localparam logic [7:0] RST_ASI = 8'h30;
   // writable bits; read-only reserved bits stay at zero
   localparam logic [7:0] SLEEP_WMASK = 8'hfd;
   localparam logic [7:0] SHDN_WMASK = 8'h3f;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int SRST_BIT = 0;
   localparam int SUPPLY_BIT = 7;
   localparam int REFQ_LSB = 3;
   localparam int BCAST_BIT = 2;
   localparam int SLEEP_BIT = 0;
   localparam int INCAP_LSB = 4;
   localparam int FMT_LSB = 6;
   localparam int WLEN_LSB = 4;
   localparam int FSINV_BIT = 3;
   localparam int BCINV_BIT = 2;
   localparam int EDGE_BIT = 1;
   localparam int FILL_BIT = 0;
   // ---------------------------------------------------------------
   // encodings
   // ---------------------------------------------------------------
   localparam logic [6:0] BCAST_ADDR = 7'h4c;
   localparam logic [1:0] FMT_TDM = 2'h0;
   localparam logic [1:0] FMT_I2S = 2'h1;
   localparam logic [1:0] FMT_LJ = 2'h2;
   localparam logic [5:0] WLEN_BITS [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int TMR_W = 21;
   localparam int REF_US [4] = '{3500, 10000, 50000, 100000};
   localparam int INCAP_US [4] = '{2500, 12500, 25000, 50000};
   // ---------------------------------------------------------------
   // state types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK, ST_WR, ST_WACK, ST_RD, ST_RACK} aacr_i2c_e;
   typedef enum logic [1:0] {CH_IDLE, CH_REF, CH_INCAP} aacr_chg_e;
endpackage

// File: hdl/audio_adc_control_registers.sv
/*
 holds the page 0 control registers of the audio ADC behind its I2C control port, with the
 soft reset and the quick-charge sequencing that follows a sleep exit.
 assumes a 20 MHz clock and a host that keeps to the reserved-field conventions.
*/
// Behaviour
// - page register at offset zero, resets to 0
// - writing 1 resets all registers, self clears
// - bit 7 selects analog core supply source
// - reference charge code picks 3.5-100 ms
// - broadcast enable adds fixed target address
// - sleep bit zero holds device asleep
// - input cap charge code picks 2.5-50 ms
// - reserved shutdown fields reset to 01b
// - format field picks TDM, I2S or LJ
// - word length 16/20/24/32, reset 32
// - bits 3 and 2 invert sync, clock
// - bit 1 moves launch half a cycle
// - bit 0 picks zero or hi-z fill
`timescale 1ns/1ps
module audio_adc_control_registers #(
   parameter logic [6:0] OWN_ADDR = 7'h2a, // arbitrary target address
   parameter int REF_CYC [4] = '{aacr_pkg::REF_US[0] * aacr_pkg::CLK_MHZ, aacr_pkg::REF_US[1] * aacr_pkg::CLK_MHZ,
      aacr_pkg::REF_US[2] * aacr_pkg::CLK_MHZ, aacr_pkg::REF_US[3] * aacr_pkg::CLK_MHZ},
   parameter int INCAP_CYC [4] = '{aacr_pkg::INCAP_US[0] * aacr_pkg::CLK_MHZ, aacr_pkg::INCAP_US[1] * aacr_pkg::CLK_MHZ,
      aacr_pkg::INCAP_US[2] * aacr_pkg::CLK_MHZ, aacr_pkg::INCAP_US[3] * aacr_pkg::CLK_MHZ}
) (
   input wire logic clk, // 20 MHz clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic scl_in, // i2c clock pin
   input wire logic sda_in, // i2c data pin level
   output logic sda_out, // i2c data drive level, always low
   output logic sda_oe, // i2c data drive enable
   output logic [7:0] page_sel, // selected register page
   output logic analog_supply_source, // 1 on-chip regulator
   output logic broadcast_address_enable, // broadcast address active
   output logic sleep_exit_n, // 0 keeps device asleep
   output logic ref_charge_active, // reference quick charge running
   output logic input_cap_charge_active, // input cap quick charge running
   output logic [1:0] frame_format, // 0 tdm, 1 i2s, 2 lj
   output logic [1:0] audio_word_length, // word length code
   output logic [5:0] audio_word_bits, // word length in bits
   output logic frame_sync_invert, // invert frame sync
   output logic bit_clock_invert, // invert bit clock
   output logic tx_edge_invert, // launch data on opposite edge
   output logic tx_fill_hiz // unused cycles hi-z
);
   // ---------------------------------------------------------------
   // control port
   // ---------------------------------------------------------------
   logic [7:0] reg_addr, wr_data, rd_data;
   logic wr_stb;

   aacr_i2c_target #(.OWN_ADDR(OWN_ADDR)) aacr_i2c_target_inst (
      .clk(clk),
      .nrst(nrst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_oe(sda_oe),
      .bcast_en(broadcast_address_enable),
      .reg_addr(reg_addr),
      .wr_data(wr_data),
      .wr_stb(wr_stb),
      .rd_data(rd_data)
   );
   assign sda_out = 1'b0;

   // ---------------------------------------------------------------
   // registers and charge sequencer
   // ---------------------------------------------------------------
   logic [7:0] page_r, page_nxt, sleep_r, sleep_nxt, shdn_r, shdn_nxt, asi_r, asi_nxt;
   logic srst_r, srst_nxt, sleep_d_r, sleep_d_nxt;
   aacr_pkg::aacr_chg_e ch_r, ch_nxt;
   logic [aacr_pkg::TMR_W-1:0] tmr_r, tmr_nxt;
   wire pg0 = (page_r == aacr_pkg::PAGE_ZERO);
   wire [1:0] ref_code = sleep_r[aacr_pkg::REFQ_LSB +: 2];
   wire [1:0] incap_code = shdn_r[aacr_pkg::INCAP_LSB +: 2];

   always_comb begin
      page_nxt = page_r;
      sleep_nxt = sleep_r;
      shdn_nxt = shdn_r;
      asi_nxt = asi_r;
      srst_nxt = 1'b0;
      sleep_d_nxt = sleep_r[aacr_pkg::SLEEP_BIT];
      ch_nxt = ch_r;
      tmr_nxt = tmr_r;
      if (srst_r) begin
         // two cycles after the write request page, sleep, shutdown and ASI registers are back at their defaults
         page_nxt = aacr_pkg::RST_PAGE;
         sleep_nxt = aacr_pkg::RST_SLEEP;
         shdn_nxt = aacr_pkg::RST_SHDN;
         asi_nxt = aacr_pkg::RST_ASI;
      end else if (wr_stb) begin
         if (reg_addr == aacr_pkg::OFS_PAGE) begin
            page_nxt = wr_data;
         end else if (pg0) begin
            case (reg_addr)
               aacr_pkg::OFS_SRST: srst_nxt = wr_data[aacr_pkg::SRST_BIT];
               aacr_pkg::OFS_SLEEP: sleep_nxt = wr_data & aacr_pkg::SLEEP_WMASK;
               aacr_pkg::OFS_SHDN: shdn_nxt = wr_data & aacr_pkg::SHDN_WMASK;
               aacr_pkg::OFS_ASI: asi_nxt = wr_data;
               default: ;
            endcase
         end
      end
      // charging starts on leaving sleep; going back to sleep aborts it
      case (ch_r)
         aacr_pkg::CH_IDLE: begin
            if (sleep_r[aacr_pkg::SLEEP_BIT] && !sleep_d_r) begin
               ch_nxt = aacr_pkg::CH_REF;
               tmr_nxt = aacr_pkg::TMR_W'(REF_CYC[ref_code]);
            end
         end
         aacr_pkg::CH_REF: begin
            if (!sleep_r[aacr_pkg::SLEEP_BIT]) begin
               ch_nxt = aacr_pkg::CH_IDLE;
            end else if (tmr_r <= aacr_pkg::TMR_W'(1)) begin
               ch_nxt = aacr_pkg::CH_INCAP;
               tmr_nxt = aacr_pkg::TMR_W'(INCAP_CYC[incap_code]);
            end else begin
               tmr_nxt = tmr_r - aacr_pkg::TMR_W'(1);
            end
         end
         aacr_pkg::CH_INCAP: begin
            if (!sleep_r[aacr_pkg::SLEEP_BIT] || tmr_r <= aacr_pkg::TMR_W'(1)) begin
               ch_nxt = aacr_pkg::CH_IDLE;
            end else begin
               tmr_nxt = tmr_r - aacr_pkg::TMR_W'(1);
            end
         end
         default: ch_nxt = aacr_pkg::CH_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         page_r <= aacr_pkg::RST_PAGE;
         sleep_r <= aacr_pkg::RST_SLEEP;
         shdn_r <= aacr_pkg::RST_SHDN;
         asi_r <= aacr_pkg::RST_ASI;
         srst_r <= 1'b0;
         sleep_d_r <= 1'b0;
         ch_r <= aacr_pkg::CH_IDLE;
         tmr_r <= '0;
      end else begin
         page_r <= page_nxt;
         sleep_r <= sleep_nxt;
         shdn_r <= shdn_nxt;
         asi_r <= asi_nxt;
         srst_r <= srst_nxt;
         sleep_d_r <= sleep_d_nxt;
         ch_r <= ch_nxt;
         tmr_r <= tmr_nxt;
      end
   end

   // ---------------------------------------------------------------
   // read mux and outputs
   // ---------------------------------------------------------------
   always_comb begin
      rd_data = 8'h00;
      if (reg_addr == aacr_pkg::OFS_PAGE) begin
         rd_data = page_r;
      end else if (pg0) begin
         case (reg_addr)
            aacr_pkg::OFS_SRST: rd_data = {7'h00, srst_r};
            aacr_pkg::OFS_SLEEP: rd_data = sleep_r;
            aacr_pkg::OFS_SHDN: rd_data = shdn_r;
            aacr_pkg::OFS_ASI: rd_data = asi_r;
            default: rd_data = 8'h00;
         endcase
      end
   end

   assign page_sel = page_r;
   assign analog_supply_source = sleep_r[aacr_pkg::SUPPLY_BIT];
   assign broadcast_address_enable = sleep_r[aacr_pkg::BCAST_BIT];
   assign sleep_exit_n = sleep_r[aacr_pkg::SLEEP_BIT];
   assign ref_charge_active = (ch_r == aacr_pkg::CH_REF);
   assign input_cap_charge_active = (ch_r == aacr_pkg::CH_INCAP);
   assign frame_format = asi_r[aacr_pkg::FMT_LSB +: 2];
   assign audio_word_length = asi_r[aacr_pkg::WLEN_LSB +: 2];
   assign audio_word_bits = aacr_pkg::WLEN_BITS[audio_word_length];
   assign frame_sync_invert = asi_r[aacr_pkg::FSINV_BIT];
   assign bit_clock_invert = asi_r[aacr_pkg::BCINV_BIT];
   assign tx_edge_invert = asi_r[aacr_pkg::EDGE_BIT];
   assign tx_fill_hiz = asi_r[aacr_pkg::FILL_BIT];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire wr_ok = wr_stb && pg0 && !srst_r;
   sequence s_srst_req;
      wr_ok && reg_addr == aacr_pkg::OFS_SRST && wr_data[0];
   endsequence
   sequence s_srst_done;
      srst_r ##1 (!srst_r && page_r == 8'h00 && sleep_r == 8'h00 && shdn_r == 8'h05 && asi_r == 8'h30);
   endsequence

   a_page_write: assert property (wr_stb && !srst_r && reg_addr == 8'h00 |=> page_r == $past(wr_data))
      else $error("page register not written");
   a_srst_defaults: assert property (s_srst_req |=> s_srst_done)
      else $error("soft reset did not restore defaults");
   a_srst_zero: assert property (wr_ok && reg_addr == aacr_pkg::OFS_SRST && !wr_data[0] |=> !srst_r && $stable(asi_r))
      else $error("writing zero to soft reset had an effect");
   a_srst_clear: assert property (srst_r |=> !srst_r && (reg_addr != aacr_pkg::OFS_SRST || rd_data == 8'h00))
      else $error("soft reset bit did not self clear");
   a_supply_sel: assert property (wr_ok && reg_addr == aacr_pkg::OFS_SLEEP |=> analog_supply_source == $past(wr_data[7]) && !sleep_r[1])
      else $error("supply select not taken");
   a_ref_length: assert property ($rose(ref_charge_active) |-> tmr_r == aacr_pkg::TMR_W'(REF_CYC[ref_code]))
      else $error("reference charge length wrong");
   a_incap_length: assert property ($rose(input_cap_charge_active) |-> $past(ref_charge_active) && tmr_r == aacr_pkg::TMR_W'(INCAP_CYC[incap_code]))
      else $error("input cap charge length wrong");
   a_sleep_hold: assert property (!sleep_exit_n |=> !ref_charge_active && !input_cap_charge_active)
      else $error("charging while asleep");
   a_word_bits: assert property (wr_ok && reg_addr == aacr_pkg::OFS_ASI |=> audio_word_bits == aacr_pkg::WLEN_BITS[$past(wr_data[5:4])] && frame_format == $past(wr_data[7:6]))
      else $error("word length or format wrong");
   a_asi_flags: assert property (wr_ok && reg_addr == aacr_pkg::OFS_ASI |=> {frame_sync_invert, bit_clock_invert, tx_edge_invert, tx_fill_hiz} == $past(wr_data[3:0]))
      else $error("serial port flags wrong");
endmodule
